// ### rtl/adc_fmt_pkg.sv
// Purpose: Shared constants for the converter control and result formatter
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: Offsets are byte addresses
package adc_fmt_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CLKDIV = 8'h04;
    localparam logic [7:0] OFS_SCAN_LOW = 8'h08;
    localparam logic [7:0] OFS_CTM_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CTM_LOW = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RESULT_FORMAT_FIELD_LSB = 8;
    localparam int CTRL_RES_BIT = 10;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CHAN_LSB = 4;
    localparam int STAT_STATE_LSB = 8;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_SCAN_LOW = 16'h0000;
    localparam logic [1:0] RST_CTM_HIGH = 2'h0;
    localparam logic [15:0] RST_CTM_LOW = 16'h0000;
    localparam logic [7:0] RST_CLKDIV = 8'h00;
    localparam logic [1:0] RST_RESULT_FORMAT_FIELD = 2'h0;
    localparam logic RST_RES = 1'b0;

    // ==========================================================
    // Timing: instruction cycle is two oscillator periods
    localparam int OSC_PER_INSTR = 2;
    localparam int SAMPLE_TADS = 1;
    localparam int CONV_TADS = 14;

    // ==========================================================
    // Converter code limits in 12-bit LSb units
    localparam logic signed [15:0] CODE_MAX = 16'sh0fff;
    localparam logic signed [15:0] CODE_MIN = -16'sh1000;

    typedef enum logic [1:0] {
        FMT_INT = 2'h0,
        FMT_SINT = 2'h1,
        FMT_FRAC = 2'h2,
        FMT_SFRAC = 2'h3
    } result_fmt_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_CONVERT = 2'h3,
        ST_DONE = 2'h2
    } conv_state_e;

endpackage

// ### rtl/fmt_if.sv
`timescale 1ns/1ps
// Purpose: Carries a raw conversion code to the formatter and back
// Assumes: Code is two's complement, 13 bits, 10-bit codes sign-extended
// Notes: None
interface fmt_if;
    logic signed [12:0] code;
    logic resolution_select;
    adc_fmt_pkg::result_fmt_e result_format_field;
    logic [15:0] word;

    modport ctrl (output code, output resolution_select, output result_format_field, input word);
    modport fmt (input code, input resolution_select, input result_format_field, output word);
endinterface

// ### rtl/result_formatter.sv
`timescale 1ns/1ps
// Purpose: Packs a conversion code into the 16-bit buffer word
// Assumes: Purely combinational; caller registers the word
// Notes: Unsigned formats clip negative codes to zero
module result_formatter (
    fmt_if.fmt f
);
    always_comb begin
        f.word = 16'h0000;
        case (f.result_format_field)
            adc_fmt_pkg::FMT_INT: begin
                if (!f.code[12]) begin
                    if (f.resolution_select) begin
                        f.word = {4'h0, f.code[11:0]};
                    end else begin
                        f.word = {6'h00, f.code[9:0]};
                    end
                end
            end
            adc_fmt_pkg::FMT_SINT: begin
                // Sign replicated upward from bit 12 at either resolution
                f.word = {{3{f.code[12]}}, f.code};
            end
            adc_fmt_pkg::FMT_FRAC: begin
                if (!f.code[12]) begin
                    if (f.resolution_select) begin
                        f.word = {f.code[11:0], 4'h0};
                    end else begin
                        f.word = {f.code[9:0], 6'h00};
                    end
                end
            end
            adc_fmt_pkg::FMT_SFRAC: begin
                if (f.resolution_select) begin
                    f.word = {f.code, 3'h0};
                end else begin
                    f.word = {f.code[10:0], 5'h00};
                end
            end
            default: begin
                f.word = 16'h0000;
            end
        endcase
    end
endmodule

// ### rtl/adc_scan_ctrl.sv
// Purpose: Scan sequencing, conversion clock and result formatting
// Assumes: Front end delivers the input difference in 12-bit LSb units
// Notes: APB slave answers in the first access cycle
`timescale 1ns/1ps
module adc_scan_ctrl #(
    parameter logic [15:0] IMPL_CH_MASK = 16'h9fff,
    parameter logic [1:0] IMPL_CTM_HIGH = 2'h3,
    parameter int SAMPLE_TADS = adc_fmt_pkg::SAMPLE_TADS,
    parameter int CONV_TADS = adc_fmt_pkg::CONV_TADS
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Analog front end
    input wire logic signed [15:0] i_vin_lsb,
    // Converter control
    output logic [3:0] o_chan_sel,
    output logic o_sampling,
    output logic o_converting,
    output logic o_tad_tick,
    output logic [17:0] o_ctm_connect,
    output logic [15:0] o_result,
    output logic o_result_valid
);

    // ==========================================================
    // Helpers
    function automatic logic [4:0] next_chan(input logic [15:0] mask,
                                             input logic [4:0] from);
        logic [4:0] r;
        r = 5'h10;
        for (int i = 15; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic signed [12:0] quantize(
        input logic signed [15:0] v, input logic m12);
        logic signed [15:0] c;
        c = v;
        if (v > adc_fmt_pkg::CODE_MAX) begin
            c = adc_fmt_pkg::CODE_MAX;
        end else if (v < adc_fmt_pkg::CODE_MIN) begin
            c = adc_fmt_pkg::CODE_MIN;
        end
        // Floor in LSb units puts the first step at one LSb
        if (!m12) begin
            c = c >>> 2;
        end
        return c[12:0];
    endfunction

    // ==========================================================
    // Registers
    logic [15:0] scan_low_q;
    logic [1:0] ctm_high_q;
    logic [15:0] ctm_low_q;
    logic [7:0] clkdiv_q;
    logic res12_q;
    adc_fmt_pkg::result_fmt_e result_format_field_q;
    logic start_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    adc_fmt_pkg::conv_state_e state_q;
    logic [4:0] chan_q;
    logic [10:0] div_cnt_q;
    logic tick_q;
    logic [4:0] tad_cnt_q;
    logic [15:0] result_q;
    logic valid_q;
    logic [17:0] ctm_conn_q;
    logic signed [12:0] code_q;

    logic setup;
    logic wr_en;
    logic addr_ok;
    logic [10:0] tad_clks;
    logic [31:0] rd_word;
    logic [17:0] ctm_mask;
    logic conv_enter;
    logic conv_leave;

    fmt_if fbus ();

    assign setup = i_psel && !i_penable;
    assign ctm_mask = {ctm_high_q, ctm_low_q};
    assign conv_enter = state_q == adc_fmt_pkg::ST_SAMPLE && tick_q
                        && tad_cnt_q == 5'(SAMPLE_TADS - 1);
    assign conv_leave = state_q == adc_fmt_pkg::ST_CONVERT && tick_q
                        && tad_cnt_q == 5'(CONV_TADS - 1);
    assign wr_en = i_psel && i_penable && pready_q && i_pwrite;
    assign tad_clks = 11'(adc_fmt_pkg::OSC_PER_INSTR)
                      * (11'(clkdiv_q) + 11'h001);

    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (i_paddr)
            adc_fmt_pkg::OFS_CONTROL: begin
                rd_word[adc_fmt_pkg::CTRL_RES_BIT] = res12_q;
                rd_word[adc_fmt_pkg::CTRL_RESULT_FORMAT_FIELD_LSB +: 2] = result_format_field_q;
            end
            adc_fmt_pkg::OFS_CLKDIV: begin
                rd_word[7:0] = clkdiv_q;
            end
            adc_fmt_pkg::OFS_SCAN_LOW: begin
                rd_word[15:0] = scan_low_q;
            end
            adc_fmt_pkg::OFS_CTM_HIGH: begin
                rd_word[1:0] = ctm_high_q;
            end
            adc_fmt_pkg::OFS_CTM_LOW: begin
                rd_word[15:0] = ctm_low_q;
            end
            adc_fmt_pkg::OFS_RESULT: begin
                rd_word[15:0] = result_q;
            end
            adc_fmt_pkg::OFS_STATUS: begin
                rd_word[adc_fmt_pkg::STAT_BUSY_BIT] =
                    (state_q != adc_fmt_pkg::ST_IDLE);
                rd_word[adc_fmt_pkg::STAT_CHAN_LSB +: 4] = chan_q[3:0];
                rd_word[adc_fmt_pkg::STAT_STATE_LSB +: 2] = state_q;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // APB handshake: answer registered at setup, one wait-free access
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= !addr_ok;
                prdata_q <= i_pwrite ? 32'h0000_0000 : rd_word;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Software-written configuration
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            scan_low_q <= adc_fmt_pkg::RST_SCAN_LOW;
            ctm_high_q <= adc_fmt_pkg::RST_CTM_HIGH;
            ctm_low_q <= adc_fmt_pkg::RST_CTM_LOW;
            clkdiv_q <= adc_fmt_pkg::RST_CLKDIV;
            res12_q <= adc_fmt_pkg::RST_RES;
            result_format_field_q <= adc_fmt_pkg::result_fmt_e'(adc_fmt_pkg::RST_RESULT_FORMAT_FIELD);
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_en) begin
                case (i_paddr)
                    adc_fmt_pkg::OFS_CONTROL: begin
                        res12_q <= i_pwdata[adc_fmt_pkg::CTRL_RES_BIT];
                        result_format_field_q <= adc_fmt_pkg::result_fmt_e'(
                            i_pwdata[adc_fmt_pkg::CTRL_RESULT_FORMAT_FIELD_LSB +: 2]);
                        start_q <= i_pwdata[adc_fmt_pkg::CTRL_START_BIT];
                    end
                    adc_fmt_pkg::OFS_CLKDIV: begin
                        clkdiv_q <= i_pwdata[7:0];
                    end
                    adc_fmt_pkg::OFS_SCAN_LOW: begin
                        scan_low_q <= i_pwdata[15:0] & IMPL_CH_MASK;
                    end
                    adc_fmt_pkg::OFS_CTM_HIGH: begin
                        ctm_high_q <= i_pwdata[1:0] & IMPL_CTM_HIGH;
                    end
                    adc_fmt_pkg::OFS_CTM_LOW: begin
                        ctm_low_q <= i_pwdata[15:0] & IMPL_CH_MASK;
                    end
                    default: begin
                        start_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Conversion clock divider
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            div_cnt_q <= 11'h000;
            tick_q <= 1'b0;
        end else if (state_q == adc_fmt_pkg::ST_IDLE) begin
            div_cnt_q <= 11'h000;
            tick_q <= 1'b0;
        end else if (div_cnt_q == tad_clks - 11'h001) begin
            div_cnt_q <= 11'h000;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 11'h001;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // Scan sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= adc_fmt_pkg::ST_IDLE;
            chan_q <= 5'h00;
            tad_cnt_q <= 5'h00;
        end else begin
            case (state_q)
                adc_fmt_pkg::ST_IDLE: begin
                    tad_cnt_q <= 5'h00;
                    // Empty mask ignores the start request
                    if (start_q && (scan_low_q != 16'h0000)) begin
                        chan_q <= next_chan(scan_low_q, 5'h00);
                        state_q <= adc_fmt_pkg::ST_SAMPLE;
                    end
                end
                adc_fmt_pkg::ST_SAMPLE: begin
                    if (tick_q) begin
                        if (tad_cnt_q == 5'(SAMPLE_TADS - 1)) begin
                            tad_cnt_q <= 5'h00;
                            state_q <= adc_fmt_pkg::ST_CONVERT;
                        end else begin
                            tad_cnt_q <= tad_cnt_q + 5'h01;
                        end
                    end
                end
                adc_fmt_pkg::ST_CONVERT: begin
                    if (tick_q) begin
                        if (tad_cnt_q == 5'(CONV_TADS - 1)) begin
                            tad_cnt_q <= 5'h00;
                            state_q <= adc_fmt_pkg::ST_DONE;
                        end else begin
                            tad_cnt_q <= tad_cnt_q + 5'h01;
                        end
                    end
                end
                adc_fmt_pkg::ST_DONE: begin
                    // Skip cleared mask bits; stop after the last set one
                    if (next_chan(scan_low_q, chan_q + 5'h01) == 5'h10) begin
                        state_q <= adc_fmt_pkg::ST_IDLE;
                    end else begin
                        chan_q <= next_chan(scan_low_q,
                                            chan_q + 5'h01);
                        state_q <= adc_fmt_pkg::ST_SAMPLE;
                    end
                end
                default: begin
                    state_q <= adc_fmt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Charge timing unit connection, held for the conversion only
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctm_conn_q <= 18'h00000;
        end else if (conv_enter
                || (state_q == adc_fmt_pkg::ST_CONVERT && !conv_leave)) begin
            // Registered on the state edges so it covers CONVERT exactly
            ctm_conn_q <= (18'h00001 << chan_q) & ctm_mask;
        end else begin
            ctm_conn_q <= 18'h00000;
        end
    end

    // ==========================================================
    // Code capture and formatting
    assign fbus.code = code_q;
    assign fbus.resolution_select = res12_q;
    assign fbus.result_format_field = result_format_field_q;

    result_formatter u_fmt (
        .f(fbus.fmt)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            code_q <= 13'h0000;
            result_q <= 16'h0000;
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            // Input held at the sample-to-convert edge
            if (conv_enter) begin
                code_q <= quantize(i_vin_lsb, res12_q);
            end
            if (state_q == adc_fmt_pkg::ST_DONE) begin
                result_q <= fbus.word;
                valid_q <= 1'b1;
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_chan_sel = chan_q[3:0];
    assign o_sampling = (state_q == adc_fmt_pkg::ST_SAMPLE);
    assign o_converting = (state_q == adc_fmt_pkg::ST_CONVERT);
    assign o_tad_tick = tick_q;
    assign o_ctm_connect = ctm_conn_q;
    assign o_result = result_q;
    assign o_result_valid = valid_q;

    // ==========================================================
    // Assertions
    property p_scan_skip;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        state_q == adc_fmt_pkg::ST_SAMPLE |-> scan_low_q[chan_q[3:0]];
    endproperty
    a_scan_skip: assert property (p_scan_skip)
        else $error("sampling a skipped channel");

    property p_mask_zero;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (scan_low_q & ~IMPL_CH_MASK) == 16'h0000
            && (ctm_low_q & ~IMPL_CH_MASK) == 16'h0000;
    endproperty
    a_mask_zero: assert property (p_mask_zero)
        else $error("unimplemented mask bit set");

    property p_ctm_conn;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        ctm_conn_q != 18'h00000 |-> state_q == adc_fmt_pkg::ST_CONVERT
            && ctm_conn_q[chan_q] && ctm_mask[chan_q];
    endproperty
    a_ctm_conn: assert property (p_ctm_conn)
        else $error("charge unit connected outside conversion");

    property p_tad_period;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        tick_q && state_q != adc_fmt_pkg::ST_IDLE |=> !tick_q;
    endproperty
    a_tad_period: assert property (p_tad_period)
        else $error("conversion clock period too short");

    property p_tad_zero_div;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        clkdiv_q == 8'h00 && $rose(tick_q) && $stable(clkdiv_q)
            |-> ##2 (tick_q || state_q == adc_fmt_pkg::ST_IDLE);
    endproperty
    a_tad_zero_div: assert property (p_tad_zero_div)
        else $error("divider zero period not two clocks");

    property p_sint_ext;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        valid_q && result_format_field_q == adc_fmt_pkg::FMT_SINT && res12_q
            |-> result_q[15:13] == {3{result_q[12]}};
    endproperty
    a_sint_ext: assert property (p_sint_ext)
        else $error("sign not replicated");

    property p_int_pos;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        valid_q && result_format_field_q == adc_fmt_pkg::FMT_INT && !res12_q
            |-> result_q[15:10] == 6'h00;
    endproperty
    a_int_pos: assert property (p_int_pos)
        else $error("10-bit integer exceeds width");

    property p_frac_low;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        valid_q && result_format_field_q == adc_fmt_pkg::FMT_FRAC && res12_q
            |-> result_q[3:0] == 4'h0;
    endproperty
    a_frac_low: assert property (p_frac_low)
        else $error("fractional low bits not zero");

    property p_clip_top;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $past(state_q) == adc_fmt_pkg::ST_SAMPLE && res12_q
            && $past(tick_q) && $past(i_vin_lsb) > 16'sh0fff
            && state_q == adc_fmt_pkg::ST_CONVERT
            |-> code_q == 13'h0fff;
    endproperty
    a_clip_top: assert property (p_clip_top)
        else $error("over-range input not all ones");

    property p_clip_zero;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $past(state_q) == adc_fmt_pkg::ST_SAMPLE && res12_q
            && $past(tick_q) && $past(i_vin_lsb) == 16'sh0000
            && state_q == adc_fmt_pkg::ST_CONVERT
            |-> code_q == 13'h0000;
    endproperty
    a_clip_zero: assert property (p_clip_zero)
        else $error("sub-LSb input not zero code");

    c_scan_done: cover property (@(posedge i_clk_sys) disable iff
        (i_sys_rst) valid_q ##1 state_q == adc_fmt_pkg::ST_SAMPLE);
    c_sfrac_neg: cover property (@(posedge i_clk_sys) disable iff
        (i_sys_rst) valid_q && result_format_field_q == adc_fmt_pkg::FMT_SFRAC
        && result_q[15]);
    c_ctm_on: cover property (@(posedge i_clk_sys) disable iff
        (i_sys_rst) ctm_conn_q != 18'h00000);

endmodule

// ### bench/adc_scan_select_result_format_tb.sv
// Purpose: Self-checking bench for scan control and result formatting
// Assumes: Default implemented-channel masks, APB answer without waits
// Notes: Front end input is held steady through each conversion
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module adc_scan_select_result_format_tb;
    // ==========================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr;
    logic signed [15:0] vin = 16'sh0000;
    logic [3:0] chan_sel;
    logic sampling, converting, tad_tick, res_valid, samp_prev = 1'b0;
    logic [17:0] ctm_connect, ctm_exp = 18'h0;
    logic [15:0] result;
    int check_count = 0;
    int n_mismatch = 0;
    int tcnt = 0;
    int tick_per = 2;
    logic tick_seen = 1'b0;
    logic [3:0] chans[$];
    int vins[5] = '{32767, 1, 0, -1, -5000};

    always #2 clk = ~clk;

    adc_scan_ctrl dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_vin_lsb(vin), .o_chan_sel(chan_sel),
        .o_sampling(sampling), .o_converting(converting),
        .o_tad_tick(tad_tick), .o_ctm_connect(ctm_connect),
        .o_result(result), .o_result_valid(res_valid));

    // ==========================================================
    // Monitors: scan order, charge-unit connect, tick spacing
    always @(posedge clk) begin
        samp_prev <= sampling;
        if (sampling && !samp_prev) chans.push_back(chan_sel);
        if (converting) `CHK("ctm_connect", (ctm_exp[chan_sel] ?
            (18'h1 << chan_sel) : 18'h0), ctm_connect)
        tcnt <= tcnt + 1;
        if (tad_tick && converting) begin
            if (tick_seen) `CHK("tick_period", tick_per, tcnt)
            tick_seen <= 1'b1;
            tcnt <= 1;
        end else if (!converting) tick_seen <= 1'b0;
    end

    // ==========================================================
    // Expected buffer word from format, resolution and input
    function automatic logic [15:0] exp_word(input int f, input int m12,
                                             input int v);
        int c;
        c = (v > 4095) ? 4095 : ((v < -4096) ? -4096 : v);
        if (m12 == 0) c = c >>> 2;
        case (f)
            0: c = (c < 0) ? 0 : c;
            2: c = (c < 0) ? 0 : c << (m12 ? 4 : 6);
            3: c = c << (m12 ? 3 : 5);
            default: c = c;
        endcase
        return c[15:0];
    endfunction

    task end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Entered just after a rising edge; holds request until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            end_sim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task run(input logic [31:0] ctl, input int nres);
        int n;
        apb(1'b1, adc_fmt_pkg::OFS_CONTROL, ctl | 32'h1);
        for (int k = 0; k < nres; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (res_valid !== 1'b1 && n < 4000);
            if (n >= 4000) begin
                n_mismatch++;
                end_sim();
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // ======================================================
        // Reset values, masking of missing channels, bad address
        apb(1'b0, adc_fmt_pkg::OFS_SCAN_LOW, 32'h0);
        `CHK("scan_rst", 32'h0, rdat)
        apb(1'b0, adc_fmt_pkg::OFS_CTM_HIGH, 32'h0);
        `CHK("ctm_high_rst", 32'h0, rdat)
        apb(1'b1, adc_fmt_pkg::OFS_SCAN_LOW, 32'hffff_a00a);
        apb(1'b0, adc_fmt_pkg::OFS_SCAN_LOW, 32'h0);
        `CHK("scan_mask", 32'h0000_800a, rdat)
        apb(1'b1, adc_fmt_pkg::OFS_CTM_HIGH, 32'hffff_ffff);
        apb(1'b0, adc_fmt_pkg::OFS_CTM_HIGH, 32'h0);
        `CHK("ctm_high", 32'h0000_0003, rdat)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("bad_addr_err", 1'b1, rerr)
        $display("test registers done");
        // ======================================================
        // Scan order with a charge-unit channel and slow divider
        tick_per = 8;
        ctm_exp = 18'h3_0008;
        apb(1'b1, adc_fmt_pkg::OFS_CLKDIV, 32'h3);
        apb(1'b1, adc_fmt_pkg::OFS_CTM_LOW, 32'h0008);
        chans.delete();
        run(32'h0, 3);
        `CHK("scan_count", 3, chans.size())
        if (chans.size() == 3) begin
            `CHK("scan_0", 4'h1, chans[0])
            `CHK("scan_1", 4'h3, chans[1])
            `CHK("scan_2", 4'hf, chans[2])
        end
        $display("test scan done");
        // ======================================================
        // Every format at both resolutions, codes at the limits
        tick_per = 2;
        ctm_exp = 18'h0;
        apb(1'b1, adc_fmt_pkg::OFS_CLKDIV, 32'h0);
        apb(1'b1, adc_fmt_pkg::OFS_CTM_LOW, 32'h0);
        apb(1'b1, adc_fmt_pkg::OFS_SCAN_LOW, 32'h0001);
        for (int r = 0; r < 2; r++) begin
            for (int f = 0; f < 4; f++) begin
                for (int v = 0; v < 5; v++) begin
                    vin <= 16'(vins[v]);
                    run(32'(r << 10 | f << 8), 1);
                    `CHK("result", exp_word(f, r, vins[v]),
                    result)
                end
            end
        end
        apb(1'b0, adc_fmt_pkg::OFS_RESULT, 32'h0);
        `CHK("result_reg", 32'(exp_word(3, 1, -5000)), rdat)
        apb(1'b0, adc_fmt_pkg::OFS_CONTROL, 32'h0);
        `CHK("control_rd", 32'h0000_0700, rdat)
        apb(1'b0, adc_fmt_pkg::OFS_STATUS, 32'h0);
        `CHK("status_idle", 32'h0, rdat)
        $display("test formats done");
        end_sim();
    end
endmodule
